/* File: ppi_printer_port.sv */
// Printer port and its host CPU register interface.
// Assumes host strobes, address and printer inputs are synchronous to mclk.
// Function
// - Follow mode: irq tracks printer done
// - Latched mode: irq released after read end
// - Irq pin floats until enable bit set
// - Read fall drives selected register to host
// - Write strobe stores host data into register
// - Output mode holds written byte on pins
// - Read active flag high during host read
// - Reset loads fixed values into all registers; host bus enable and read flag still follow the strobes
// - Choose pin open-drain, level read back
// - Direction from I/O select or control
// - Strobe pin marks valid printer data
`timescale 1ns/1ps

module ppi_printer_port (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Host CPU bus.
  input  wire logic [2:0]             host_addr_bits,
  input  wire logic                   printer_port_select_n,
  input  wire logic                   host_read_strobe_n,
  input  wire logic                   host_write_strobe_n,
  input  wire logic [7:0]             host_data_in,
  output logic      [7:0]             host_data_out,
  output logic                        host_data_oe_n,
  output logic                        read_active_flag,
  // Printer data port.
  input  wire logic [7:0]             printer_data_in,
  output logic      [7:0]             printer_data_out,
  output logic                        printer_data_oe_n,
  // Open-drain printer handshake pins.
  input  wire logic                   strobe_in_n,
  output logic                        strobe_out_n,
  output logic                        strobe_oe_n,
  input  wire logic                   setup_in_n,
  output logic                        setup_out_n,
  output logic                        setup_oe_n,
  input  wire logic                   choose_in_n,
  output logic                        printer_choose_out_n,
  output logic                        choose_oe_n,
  // Printer status inputs.
  input  wire ppi_pkg::ppi_pstat_s    pstat,
  // Mode straps.
  input  wire logic                   printer_irq_mode_sel,
  input  wire logic                   direction_source_select,
  // Interrupts.
  output logic                        printer_irq_n,
  output logic                        printer_irq_oe_n,
  output logic                        event_irq
);
  import ppi_pkg::*;

  ppi_ctrl_s             ctrl, next_ctrl;
  logic [7:0]            data_latch, next_data_latch;
  logic                  iosel_dir, next_iosel_dir;
  logic [PPI_EV_W-1:0]   ev_status, next_ev_status;
  logic [PPI_EV_W-1:0]   ev_mask, next_ev_mask;
  logic                  irq_latched, next_irq_latched;
  logic                  irq_q, next_irq_q;
  logic [7:0]            rdata, next_rdata;
  logic                  rd_prev, wr_prev, rd_sel_prev;
  ppi_pstat_s            pstat_prev;

  logic                  sel, rd_sel, rd_fall, wr_fall, rd_end;
  logic                  dir_in;
  logic [7:0]            rd_mux;
  logic [PPI_EV_W-1:0]   ev_hit;

  // Chip select gates every host access.
  assign sel     = ~printer_port_select_n;
  assign rd_sel  = sel & ~host_read_strobe_n;
  assign rd_fall = rd_prev & ~host_read_strobe_n & sel;
  assign wr_fall = wr_prev & ~host_write_strobe_n & sel;
  assign rd_end  = rd_sel_prev & host_read_strobe_n;

  // Pin-selected or software-selected port direction.
  assign dir_in = direction_source_select ? ctrl.dir_in : iosel_dir;

  assign ev_hit[PPI_EV_DONE]  = pstat_prev.done_n & ~pstat.done_n;
  assign ev_hit[PPI_EV_FAULT] = pstat_prev.fault_n & ~pstat.fault_n;
  assign ev_hit[PPI_EV_PAPER] = ~pstat_prev.paper_out & pstat.paper_out;

  always_comb begin
    rd_mux = 8'h00;
    unique case (host_addr_bits)
      PPI_OFS_DATA:  rd_mux = dir_in ? printer_data_in : data_latch;
      PPI_OFS_STAT: begin
        rd_mux[PPI_ST_PEND]   = irq_latched;
        rd_mux[PPI_ST_FAULT]  = pstat.fault_n;
        rd_mux[PPI_ST_ONLINE] = pstat.online;
        rd_mux[PPI_ST_PAPER]  = pstat.paper_out;
        rd_mux[PPI_ST_DONE]   = pstat.done_n;
      end
      PPI_OFS_CTRL:  rd_mux = {2'h0, dir_in, ctrl.irq_en, choose_in_n, setup_in_n, 1'b0,
                              strobe_in_n};
      PPI_OFS_IOSEL: rd_mux = {7'h00, dir_in};
      PPI_OFS_EVST:  rd_mux = {5'h00, ev_status};
      PPI_OFS_EVMSK: rd_mux = {5'h00, ev_mask};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_ctrl        = ctrl;
    next_data_latch  = data_latch;
    next_iosel_dir   = iosel_dir;
    next_ev_mask     = ev_mask;
    next_rdata       = rdata;
    next_ev_status   = ev_status;
    next_irq_latched = irq_latched;
    if (rd_fall) begin
      next_rdata = rd_mux;
    end
    if (wr_fall) begin
      unique case (host_addr_bits)
        PPI_OFS_DATA:  next_data_latch = host_data_in;
        PPI_OFS_CTRL:  next_ctrl = ppi_ctrl_s'(host_data_in);
        PPI_OFS_IOSEL: begin
          if (host_data_in == PPI_IOSEL_IN) begin
            next_iosel_dir = 1'b1;
          end else if (host_data_in == PPI_IOSEL_OUT) begin
            next_iosel_dir = 1'b0;
          end
        end
        PPI_OFS_EVST:  next_ev_status = ev_status & ~host_data_in[PPI_EV_W-1:0];
        PPI_OFS_EVMSK: next_ev_mask = host_data_in[PPI_EV_W-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_ev_status = next_ev_status | ev_hit;
    // Latched printer interrupt: set by done falling, freed at read end.
    if (rd_end) begin
      next_irq_latched = 1'b0;
    end
    if (printer_irq_mode_sel && ev_hit[PPI_EV_DONE]) begin
      next_irq_latched = 1'b1;
    end
    if (!printer_irq_mode_sel) begin
      next_irq_latched = 1'b0;
    end
    // Follow mode copies the done level; latched mode shows the latch.
    next_irq_q = printer_irq_mode_sel ? next_irq_latched : ~pstat.done_n;
  end

  // All state clears to constants while reset is held.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= ppi_ctrl_s'(PPI_RST_CTRL);
      data_latch  <= PPI_RST_DATA;
      iosel_dir   <= PPI_RST_DIR;
      ev_status   <= '0;
      ev_mask     <= '0;
      irq_latched <= 1'b0;
      irq_q       <= 1'b0;
      rdata       <= 8'h00;
      rd_prev     <= 1'b1;
      wr_prev     <= 1'b1;
      rd_sel_prev <= 1'b0;
      pstat_prev  <= '{done_n: 1'b1, fault_n: 1'b1, paper_out: 1'b0, online: 1'b1};
    end else begin
      ctrl        <= next_ctrl;
      data_latch  <= next_data_latch;
      iosel_dir   <= next_iosel_dir;
      ev_status   <= next_ev_status;
      ev_mask     <= next_ev_mask;
      irq_latched <= next_irq_latched;
      irq_q       <= next_irq_q;
      rdata       <= next_rdata;
      rd_prev     <= host_read_strobe_n;
      wr_prev     <= host_write_strobe_n;
      rd_sel_prev <= rd_sel;
      pstat_prev  <= pstat;
    end
  end

  // Host bus and read flag; the enable is combinational so the bus frees at once.
  assign host_data_out    = rdata;
  assign host_data_oe_n   = ~rd_sel;
  assign read_active_flag = rd_sel;

  // Printer data port drives the held byte only in output mode.
  assign printer_data_out  = data_latch;
  assign printer_data_oe_n = dir_in;

  // Open-drain pins only ever pull low, so the output value is a constant 0.
  assign strobe_out_n         = 1'b0;
  assign strobe_oe_n          = ~ctrl.strobe;
  assign setup_out_n          = 1'b0;
  assign setup_oe_n           = ~ctrl.setup;
  assign printer_choose_out_n = 1'b0;
  assign choose_oe_n          = ~ctrl.choose;

  // Printer interrupt floats until enabled.
  assign printer_irq_n    = ~irq_q;
  assign printer_irq_oe_n = ~ctrl.irq_en;

  assign event_irq = |(ev_status & ev_mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_irq_follow_done: assert property (
    !printer_irq_mode_sel && !$past(printer_irq_mode_sel) |-> printer_irq_n == $past(pstat.done_n))
    else $error("Follow mode irq does not track done.");

  a_irq_latch_hold: assert property (
    $past(printer_irq_mode_sel) && printer_irq_mode_sel && !printer_irq_n && !rd_end &&
      !ev_hit[PPI_EV_DONE] ##1 printer_irq_mode_sel |-> !printer_irq_n)
    else $error("Latched irq released without read end.");

  a_irq_latch_free: assert property (
    printer_irq_mode_sel && rd_end && !ev_hit[PPI_EV_DONE] ##1 printer_irq_mode_sel
      |-> printer_irq_n)
    else $error("Latched irq not released at read end.");

  a_irq_float: assert property (
    wr_fall && host_addr_bits == PPI_OFS_CTRL |=> printer_irq_oe_n == !$past(host_data_in[4]))
    else $error("Irq pin driven while disabled.");

  a_read_data: assert property (
    rd_fall && host_addr_bits == PPI_OFS_IOSEL |=> host_data_out == {7'h00, $past(dir_in)})
    else $error("Read data wrong one cycle after strobe.");

  a_write_ctrl: assert property (
    wr_fall && host_addr_bits == PPI_OFS_CTRL |=> ctrl == $past(host_data_in))
    else $error("Control write not stored.");

  a_data_held: assert property (
    !dir_in && !(wr_fall && host_addr_bits == PPI_OFS_DATA)
      |=> printer_data_out == $past(printer_data_out))
    else $error("Printer data changed without write.");

  a_read_flag: assert property (
    read_active_flag == (sel && !host_read_strobe_n))
    else $error("Read active flag wrong.");

  a_choose_pin: assert property (
    wr_fall && host_addr_bits == PPI_OFS_CTRL && host_data_in[3] |=> !choose_oe_n)
    else $error("Choose pin not driven after write.");

  a_dir_source: assert property (
    direction_source_select |-> printer_data_oe_n == ctrl.dir_in)
    else $error("Direction not from control bit.");

  a_bus_float: assert property (
    printer_port_select_n || host_read_strobe_n |-> host_data_oe_n)
    else $error("Host bus driven outside a read.");

endmodule

/* File: ppi_pkg.sv */
// Constants and carrier types for the printer port host interface.
// Assumes a single 40 MHz clock domain and host pins sampled synchronously.
package ppi_pkg;

  // Register offsets on the host address bits.
  localparam logic [2:0] PPI_OFS_DATA  = 3'h0;
  localparam logic [2:0] PPI_OFS_STAT  = 3'h1;
  localparam logic [2:0] PPI_OFS_CTRL  = 3'h2;
  localparam logic [2:0] PPI_OFS_IOSEL = 3'h3;
  localparam logic [2:0] PPI_OFS_EVST  = 3'h4;
  localparam logic [2:0] PPI_OFS_EVMSK = 3'h5;

  // Patterns written to the I/O select register.
  localparam logic [7:0] PPI_IOSEL_IN  = 8'hAA;
  localparam logic [7:0] PPI_IOSEL_OUT = 8'h55;

  // Event bit positions in the event status and mask registers.
  localparam int PPI_EV_DONE  = 0;
  localparam int PPI_EV_FAULT = 1;
  localparam int PPI_EV_PAPER = 2;
  localparam int PPI_EV_W     = 3;

  // Status register bit positions.
  localparam int PPI_ST_PEND   = 2;
  localparam int PPI_ST_FAULT  = 3;
  localparam int PPI_ST_ONLINE = 4;
  localparam int PPI_ST_PAPER  = 5;
  localparam int PPI_ST_DONE   = 6;

  // Reset values.
  localparam logic [7:0] PPI_RST_CTRL  = 8'h00;
  localparam logic [7:0] PPI_RST_DATA  = 8'h00;
  localparam logic       PPI_RST_DIR   = 1'b0;

  // Printer control register; a set drive bit pulls its open-drain pin low.
  typedef struct packed {
    logic [1:0] spare;
    logic       dir_in;
    logic       irq_en;
    logic       choose;
    logic       setup;
    logic       spare0;
    logic       strobe;
  } ppi_ctrl_s;

  // Sampled printer status inputs.
  typedef struct packed {
    logic done_n;
    logic fault_n;
    logic paper_out;
    logic online;
  } ppi_pstat_s;

endpackage

/* File: ppi_printer_model.sv */
// Behavioural printer on the far side of the parallel port.
// Assumes the bench resolves the open-drain pins with their pull-ups.
`timescale 1ns/1ps
module ppi_printer_model (
  // Clock and pins from the port.
  input  wire logic        mclk,
  input  wire logic        setup_pin_n,
  input  wire logic        port_oe_n,
  input  wire logic [7:0]  port_data,
  // Requests from the bench: done, fault, paper out, offline.
  input  wire logic [3:0]  req,
  input  wire logic [7:0]  reply,
  // Printer outputs.
  output ppi_pkg::ppi_pstat_s pstat,
  output logic [7:0]       pin_data
);
  import ppi_pkg::*;
  // A printer held in initialisation withdraws its fault report.
  always_ff @(posedge mclk) begin
    pstat.done_n    <= ~req[0];
    pstat.fault_n   <= ~req[1] | ~setup_pin_n;
    pstat.paper_out <= req[2];
    pstat.online    <= ~req[3];
  end
  // The printer only drives the data lines once the port has let go of them.
  assign pin_data = port_oe_n ? reply : port_data;
endmodule

/* File: ppi_printer_port_tb_top.sv */
// Self-checking bench for the printer port host interface.
// Assumes the printer model file and the design package are compiled first.
`timescale 1ns/1ps
module ppi_printer_port_tb_top;
  import ppi_pkg::*;
  logic       mclk, rst_n, cs_n, rd_n, wr_n, mode, dss;
  logic [2:0] addr;
  logic [7:0] wdata, reply, rdata, hd_out, pd_out, pd_in;
  logic [3:0] req;
  logic       hd_oe_n, ra, pd_oe_n, st_o, st_oe, su_o, su_oe, ch_o, ch_oe;
  logic       irq_n, irq_oe_n, ev_irq;
  ppi_pstat_s pstat;
  int         miscompares, comparisons, cycles = 0;
  // Open-drain pins float to their pull-up level when released.
  wire st_pin = st_oe ? 1'b1 : st_o;
  wire su_pin = su_oe ? 1'b1 : su_o;
  wire ch_pin = ch_oe ? 1'b1 : ch_o;

  ppi_printer_port DUT (.mclk(mclk), .rst_n(rst_n), .host_addr_bits(addr),
    .printer_port_select_n(cs_n), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .host_data_in(wdata), .host_data_out(hd_out), .host_data_oe_n(hd_oe_n),
    .read_active_flag(ra), .printer_data_in(pd_in), .printer_data_out(pd_out),
    .printer_data_oe_n(pd_oe_n), .strobe_in_n(st_pin), .strobe_out_n(st_o),
    .strobe_oe_n(st_oe), .setup_in_n(su_pin), .setup_out_n(su_o), .setup_oe_n(su_oe),
    .choose_in_n(ch_pin), .printer_choose_out_n(ch_o), .choose_oe_n(ch_oe),
    .pstat(pstat), .printer_irq_mode_sel(mode), .direction_source_select(dss),
    .printer_irq_n(irq_n), .printer_irq_oe_n(irq_oe_n), .event_irq(ev_irq));
  ppi_printer_model printer (.mclk(mclk), .setup_pin_n(su_pin), .port_oe_n(pd_oe_n),
    .port_data(pd_out), .req(req), .reply(reply), .pstat(pstat), .pin_data(pd_in));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One access with a one-cycle strobe; entered and left at a rising edge.
  task automatic acc(input logic sel_n, input logic wr, input logic [2:0] a,
                     input logic [7:0] d);
    cs_n <= sel_n;
    addr <= a;
    wdata <= d;
    wr_n <= ~wr;
    rd_n <= wr;
    #1 chk("rd_flags", {6'h0, ra, hd_oe_n}, {6'h0, ~wr & ~sel_n, wr | sel_n});
    @(posedge mclk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    #1 rdata = hd_out;
    @(posedge mclk);
  endtask

  task automatic dir(input logic d, input logic [2:0] a, input logic [7:0] v, input logic e);
    dss <= d;
    acc(1'b0, 1'b1, a, v);
    chk("pdata_oe", {7'h0, pd_oe_n}, {7'h0, e});
  endtask

  task automatic pulse(input int bit_no, input int hold);
    req[bit_no] <= 1'b1;
    repeat (hold) @(posedge mclk);
    req[bit_no] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    rst_n = 1'b0; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; addr = 3'h0; wdata = 8'h00;
    mode = 1'b0; dss = 1'b0; req = 4'h0; reply = 8'h3C; miscompares = 0; comparisons = 0;
    repeat (10) @(posedge mclk);
    chk("reset_pins", {1'b0, irq_n, irq_oe_n, st_oe, su_oe, ch_oe, ev_irq, pd_oe_n}, 8'h7C);
    rst_n <= 1'b1;
    @(posedge mclk);
    acc(1'b0, 1'b1, PPI_OFS_DATA, 8'hA5);
    chk("pdata", pd_out, 8'hA5);
    acc(1'b1, 1'b1, PPI_OFS_DATA, 8'h11);
    acc(1'b1, 1'b0, PPI_OFS_DATA, 8'h00);
    acc(1'b0, 1'b0, PPI_OFS_DATA, 8'h00);
    chk("data_rd", rdata, 8'hA5);
    acc(1'b0, 1'b0, 3'h6, 8'h00);
    chk("unmapped", rdata, 8'h00);
    $display("test host access done");
    dir(1'b0, PPI_OFS_IOSEL, PPI_IOSEL_IN, 1'b1);
    acc(1'b0, 1'b0, PPI_OFS_IOSEL, 8'h00);
    chk("iosel_rd", rdata, 8'h01);
    acc(1'b0, 1'b0, PPI_OFS_DATA, 8'h00);
    chk("pin_rd", rdata, 8'h3C);
    dir(1'b0, PPI_OFS_IOSEL, 8'h12, 1'b1);
    dir(1'b0, PPI_OFS_IOSEL, PPI_IOSEL_OUT, 1'b0);
    dir(1'b1, PPI_OFS_CTRL, 8'h20, 1'b1);
    dir(1'b1, PPI_OFS_CTRL, 8'h00, 1'b0);
    dss <= 1'b0;
    $display("test direction done");
    acc(1'b0, 1'b1, PPI_OFS_CTRL, 8'h0D);
    chk("od_oe", {5'h0, st_oe, su_oe, ch_oe}, 8'h00);
    acc(1'b0, 1'b0, PPI_OFS_CTRL, 8'h00);
    chk("cmd_pins", rdata & 8'h0D, 8'h00);
    pulse(0, 3);
    chk("irq_float", {6'h0, irq_oe_n, irq_n}, 8'h03);
    acc(1'b0, 1'b1, PPI_OFS_CTRL, 8'h10);
    acc(1'b0, 1'b0, PPI_OFS_CTRL, 8'h00);
    chk("cmd_pins", rdata & 8'h0D, 8'h0D);
    req[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("irq_follow", {6'h0, irq_oe_n, irq_n}, 8'h00);
    req[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("irq_follow", {7'h0, irq_n}, 8'h01);
    mode <= 1'b1;
    pulse(0, 1);
    chk("irq_latch", {7'h0, irq_n}, 8'h00);
    acc(1'b0, 1'b0, PPI_OFS_STAT, 8'h00);
    chk("pending", {7'h0, rdata[PPI_ST_PEND]}, 8'h01);
    repeat (2) @(posedge mclk);
    chk("irq_latch", {7'h0, irq_n}, 8'h01);
    $display("test printer irq done");
    acc(1'b0, 1'b1, PPI_OFS_EVST, 8'h07);
    acc(1'b0, 1'b1, PPI_OFS_EVMSK, 8'h07);
    acc(1'b0, 1'b0, PPI_OFS_EVMSK, 8'h00);
    chk("ev_mask_rd", rdata, 8'h07);
    req[1] <= 1'b1;
    req[3] <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, 1'b0, PPI_OFS_STAT, 8'h00);
    chk("status", rdata & 8'h58, 8'h40);
    acc(1'b0, 1'b0, PPI_OFS_EVST, 8'h00);
    chk("ev_fault", {rdata[6:0], ev_irq}, 8'h05);
    acc(1'b0, 1'b1, PPI_OFS_EVST, 8'h02);
    chk("ev_clear", {7'h0, ev_irq}, 8'h00);
    acc(1'b0, 1'b1, PPI_OFS_CTRL, 8'h04);
    req[2] <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, 1'b0, PPI_OFS_STAT, 8'h00);
    chk("setup_paper", rdata & 8'h28, 8'h28);
    acc(1'b0, 1'b1, PPI_OFS_EVMSK, 8'h00);
    acc(1'b0, 1'b0, PPI_OFS_EVST, 8'h00);
    chk("ev_masked", {rdata[6:0], ev_irq}, 8'h08);
    $display("test events done");
    give_verdict();
  end
endmodule
